// ---- verilog/io_port_pkg.sv ----
// Constants, register map and field layout of the general-purpose port block
// Operation
// - Port A pins each have a wake enable bit, one enables, reset zero.
// - Every implemented pin except port A pin 7 has a pull-high enable bit, one connects, reset zero.
// - Bit positions without a pin ignore writes and read back as zero.
// - Ports A to F each have their own direction register, rewritable any time.
// - Reading an input pin returns the level present on the pin.
// - A pin with direction zero is driven push-pull from its output latch, or from its shared output while that is selected.
// - Reading an output pin returns the latch value, not the pin level.
// - External interrupt samples its pin only when enabled and port A bit 3 is input.
// - Timer input pins feed the timer only in event or capture mode and as inputs.
// - Divider output reaches its pin only when selected and the pin is output.
// - Each PWM output drives its pin only when selected and the pin is output.
// - Port B pins 0 to 3 serve as half-bias LCD commons under a control register while they are set as inputs.
// - A pin chosen as converter input loses its pull-high whatever its enable bit.
// - In idle or sleep, a falling edge on a wake-enabled port A pin wakes the device.
// - Port A pin 7 has no pull-high; that enable bit is unimplemented.
// - Output data is latched until rewritten; input reads are not latched.
package io_port_pkg;

   localparam int NUM_PORTS = 6;
   localparam int PORT_W = 8;
   localparam int ADDR_W = 5;

   // Port numbers, also the upper address field
   localparam logic [2:0] PORT_A = 3'h0;
   localparam logic [2:0] PORT_B = 3'h1;
   localparam logic [2:0] PORT_F = 3'h5;

   // Register slot within a port (low address field)
   localparam logic [1:0] SLOT_DATA = 2'h0;
   localparam logic [1:0] SLOT_DIR = 2'h1;
   localparam logic [1:0] SLOT_PULL = 2'h2;
   localparam logic [1:0] SLOT_EXTRA = 2'h3;

   // Which bit positions carry a pin
   localparam logic [7:0] IMPL_MASK [NUM_PORTS] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03};
   // Pull-high positions; port A pin 7 has none
   localparam logic [7:0] PULL_MASK [NUM_PORTS] = '{8'h7f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h03};

   localparam logic [7:0] DATA_RESET = 8'hff;
   localparam logic [7:0] PULL_RESET = 8'h00;
   localparam logic [7:0] WAKE_RESET = 8'h00;
   localparam logic [7:0] LCD_RESET = 8'h00;
   localparam logic [7:0] LCD_MASK = 8'h1f;

   // LCD common control fields
   localparam int LCD_BIAS_BIT = 4;
   localparam int LCD_COMS = 4;

   // Shared function pin positions
   localparam int INT_BIT = 3;
   localparam int PFD_BIT = 1;
   localparam int TC0_BIT = 2;
   localparam int TC1_BIT = 4;
   localparam int TC2_BIT = 5;
   localparam int NUM_TIMERS = 3;
   localparam int NUM_PWM = 3;

endpackage

// ---- verilog/io_pin_cell.sv ----
// One port's output stage: drive value, enable, pull-high and half-bias control
`timescale 1ns/1ps
module io_pin_cell #(
   parameter int WIDTH = 8
) (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] dir_i, // One is input
   input wire logic [WIDTH-1:0] latch_i, // Output data latch
   input wire logic [WIDTH-1:0] pull_en_i, // Pull-high enable bits
   input wire logic [WIDTH-1:0] alt_en_i, // Shared output selected
   input wire logic [WIDTH-1:0] alt_val_i, // Shared output value
   input wire logic [WIDTH-1:0] analog_i, // Pin used as converter input
   input wire logic [WIDTH-1:0] com_en_i, // Pin used as LCD common
   output logic [WIDTH-1:0] pin_o, // Pin drive level
   output logic [WIDTH-1:0] pin_oe_o, // High while pin is driven
   output logic [WIDTH-1:0] pull_o, // Pull-high connected
   output logic [WIDTH-1:0] half_o // Half-bias network connected
);

   logic [WIDTH-1:0] pin_nxt, oe_nxt, pull_nxt, half_nxt;

   always_comb begin
      oe_nxt = ~dir_i;
      pin_nxt = (alt_en_i & alt_val_i) | (~alt_en_i & latch_i);
      half_nxt = com_en_i & dir_i;
      // Pull only on an input; converter use wins over the enable bit
      pull_nxt = pull_en_i & dir_i & ~analog_i & ~half_nxt;
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         pin_o <= '0;
         pin_oe_o <= '0;
         pull_o <= '0;
         half_o <= '0;
      end else begin
         pin_o <= pin_nxt;
         pin_oe_o <= oe_nxt;
         pull_o <= pull_nxt;
         half_o <= half_nxt;
      end
   end

endmodule // io_pin_cell

// ---- verilog/io_wake_detect.sv ----
// Falling-edge wake detector for port A
`timescale 1ns/1ps
module io_wake_detect #(
   parameter int WIDTH = 8
) (
   input wire logic clock_i, // System clock
   input wire logic rst_n_i, // Synchronous reset, active low
   input wire logic [WIDTH-1:0] pin_i, // Port A pin levels
   input wire logic [WIDTH-1:0] enable_i, // Wake enable bits
   input wire logic halted_i, // Idle or sleep mode
   output logic wake_o // One-cycle wake pulse
);

   logic [WIDTH-1:0] last_r, last_nxt;
   logic wake_nxt;

   always_comb begin
      last_nxt = pin_i;
      wake_nxt = halted_i && |(last_r & ~pin_i & enable_i);
   end

   // Last level resets high so a pin held low at reset reads as a falling edge
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         last_r <= '1;
         wake_o <= 1'b0;
      end else begin
         last_r <= last_nxt;
         wake_o <= wake_nxt;
      end
   end

endmodule // io_wake_detect

// ---- verilog/io_port_dir_pullup_wake.sv ----
// Ports A to F: data, direction, pull-high and wake registers with pin sharing
`timescale 1ns/1ps
module io_port_dir_pullup_wake
   import io_port_pkg::*;
(
   input wire logic clock_i, // System clock, 40 MHz
   input wire logic rst_n_i, // Synchronous reset, active low
   // Data memory port
   input wire logic [ADDR_W-1:0] addr_i, // Register address
   input wire logic wr_en_i, // Write strobe
   input wire logic [PORT_W-1:0] wr_data_i, // Write data
   input wire logic rd_en_i, // Read strobe
   output logic [PORT_W-1:0] rd_data_o, // Read data, next cycle
   // Pins
   input wire logic [7:0] pa_pin_i, // Port A levels
   output logic [7:0] pa_pin_o, // Port A drive
   output logic [7:0] pa_pin_oe_o, // Port A enable
   output logic [7:0] pa_pull_o, // Port A pull-high
   input wire logic [7:0] pb_pin_i, // Port B levels
   output logic [7:0] pb_pin_o, // Port B drive
   output logic [7:0] pb_pin_oe_o, // Port B enable
   output logic [7:0] pb_pull_o, // Port B pull-high
   output logic [7:0] pb_half_o, // Port B half-bias on
   input wire logic [7:0] pc_pin_i, // Port C levels
   output logic [7:0] pc_pin_o, // Port C drive
   output logic [7:0] pc_pin_oe_o, // Port C enable
   output logic [7:0] pc_pull_o, // Port C pull-high
   input wire logic [7:0] pd_pin_i, // Port D levels
   output logic [7:0] pd_pin_o, // Port D drive
   output logic [7:0] pd_pin_oe_o, // Port D enable
   output logic [7:0] pd_pull_o, // Port D pull-high
   input wire logic [7:0] pe_pin_i, // Port E levels
   output logic [7:0] pe_pin_o, // Port E drive
   output logic [7:0] pe_pin_oe_o, // Port E enable
   output logic [7:0] pe_pull_o, // Port E pull-high
   input wire logic [1:0] pf_pin_i, // Port F levels
   output logic [1:0] pf_pin_o, // Port F drive
   output logic [1:0] pf_pin_oe_o, // Port F enable
   output logic [1:0] pf_pull_o, // Port F pull-high
   // Shared functions
   input wire logic int_enable_i, // External interrupt enabled
   output logic ext_int_o, // Interrupt pin level to controller
   input wire logic [NUM_TIMERS-1:0] timer_event_mode_i, // Event or capture mode
   output logic [NUM_TIMERS-1:0] timer_event_o, // Timer pin levels
   input wire logic pfd_select_i, // Divider output selected
   input wire logic pfd_i, // Divider output value
   input wire logic [NUM_PWM-1:0] pwm_select_i, // PWM outputs selected
   input wire logic [NUM_PWM-1:0] pwm_i, // PWM output values
   input wire logic [7:0] analog_channel_config_i, // Port B converter inputs
   input wire logic halted_i, // Idle or sleep mode
   output logic wake_o // Wake request pulse
);

   // ***********************************************************
   // Register state
   // ***********************************************************
   logic [7:0] latch_r [NUM_PORTS];
   logic [7:0] latch_nxt [NUM_PORTS];
   logic [7:0] dir_r [NUM_PORTS];
   logic [7:0] dir_nxt [NUM_PORTS];
   logic [7:0] pull_r [NUM_PORTS];
   logic [7:0] pull_nxt [NUM_PORTS];
   logic [7:0] wake_en_r, wake_en_nxt;
   logic [7:0] lcd_r, lcd_nxt;
   logic [7:0] rd_data_nxt;
   logic [NUM_TIMERS-1:0] timer_event_nxt;
   logic ext_int_nxt;
   logic [7:0] pin_in [NUM_PORTS];
   logic [2:0] port_sel;
   logic [1:0] slot_sel;
   logic hit;

   assign pin_in[0] = pa_pin_i;
   assign pin_in[1] = pb_pin_i;
   assign pin_in[2] = pc_pin_i;
   assign pin_in[3] = pd_pin_i;
   assign pin_in[4] = pe_pin_i;
   assign pin_in[5] = {6'h00, pf_pin_i};

   assign port_sel = addr_i[ADDR_W-1:2];
   assign slot_sel = addr_i[1:0];
   assign hit = (port_sel <= PORT_F);

   // ***********************************************************
   // Register writes and reads
   // ***********************************************************
   always_comb begin
      for (int i = 0; i < NUM_PORTS; i++) begin
         latch_nxt[i] = latch_r[i];
         dir_nxt[i] = dir_r[i];
         pull_nxt[i] = pull_r[i];
      end
      wake_en_nxt = wake_en_r;
      lcd_nxt = lcd_r;
      rd_data_nxt = rd_data_o;
      if (wr_en_i && hit) begin
         case (slot_sel)
            SLOT_DATA: latch_nxt[port_sel] = wr_data_i & IMPL_MASK[port_sel];
            SLOT_DIR: dir_nxt[port_sel] = wr_data_i & IMPL_MASK[port_sel];
            SLOT_PULL: pull_nxt[port_sel] = wr_data_i & PULL_MASK[port_sel];
            SLOT_EXTRA: begin
               if (port_sel == PORT_A) begin
                  wake_en_nxt = wr_data_i;
               end
               if (port_sel == PORT_B) begin
                  lcd_nxt = wr_data_i & LCD_MASK;
               end
            end
            default: ;
         endcase
      end
      if (rd_en_i) begin
         rd_data_nxt = 8'h00;
         if (hit) begin
            case (slot_sel)
               // Inputs read live, outputs read the latch
               SLOT_DATA: rd_data_nxt = ((pin_in[port_sel] & dir_r[port_sel])
                  | (latch_r[port_sel] & ~dir_r[port_sel]))
                  & IMPL_MASK[port_sel];
               SLOT_DIR: rd_data_nxt = dir_r[port_sel];
               SLOT_PULL: rd_data_nxt = pull_r[port_sel];
               SLOT_EXTRA: begin
                  if (port_sel == PORT_A) begin
                     rd_data_nxt = wake_en_r;
                  end else if (port_sel == PORT_B) begin
                     rd_data_nxt = lcd_r;
                  end
               end
               default: rd_data_nxt = 8'h00;
            endcase
         end
      end
   end

   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            latch_r[i] <= DATA_RESET & IMPL_MASK[i];
            dir_r[i] <= IMPL_MASK[i];
            pull_r[i] <= PULL_RESET;
         end
         wake_en_r <= WAKE_RESET;
         lcd_r <= LCD_RESET;
         rd_data_o <= 8'h00;
      end else begin
         for (int i = 0; i < NUM_PORTS; i++) begin
            latch_r[i] <= latch_nxt[i];
            dir_r[i] <= dir_nxt[i];
            pull_r[i] <= pull_nxt[i];
         end
         wake_en_r <= wake_en_nxt;
         lcd_r <= lcd_nxt;
         rd_data_o <= rd_data_nxt;
      end
   end

   // ***********************************************************
   // Shared inputs to other blocks
   // ***********************************************************
   always_comb begin
      ext_int_nxt = int_enable_i & dir_r[0][INT_BIT] & pa_pin_i[INT_BIT];
      timer_event_nxt[0] = timer_event_mode_i[0] & dir_r[0][TC0_BIT] & pa_pin_i[TC0_BIT];
      timer_event_nxt[1] = timer_event_mode_i[1] & dir_r[0][TC1_BIT] & pa_pin_i[TC1_BIT];
      timer_event_nxt[2] = timer_event_mode_i[2] & dir_r[0][TC2_BIT] & pa_pin_i[TC2_BIT];
   end

   // Gated functions read low, so a peripheral left off sees a quiet line
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ext_int_o <= 1'b0;
         timer_event_o <= '0;
      end else begin
         ext_int_o <= ext_int_nxt;
         timer_event_o <= timer_event_nxt;
      end
   end

   // ***********************************************************
   // Pin output stages
   // ***********************************************************
   logic [7:0] pa_alt_en, pa_alt_val, pd_alt_en, pd_alt_val, pb_com;

   always_comb begin
      pa_alt_en = 8'h00;
      pa_alt_val = 8'h00;
      pa_alt_en[PFD_BIT] = pfd_select_i;
      pa_alt_val[PFD_BIT] = pfd_i;
      pd_alt_en = {5'h00, pwm_select_i};
      pd_alt_val = {5'h00, pwm_i};
      pb_com = {4'h0, lcd_r[LCD_COMS-1:0] & {LCD_COMS{lcd_r[LCD_BIAS_BIT]}}};
   end

   // Port A pin 1 doubles as divider output
   io_pin_cell #(.WIDTH(8)) u_pa (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .dir_i(dir_r[0]),
      .latch_i(latch_r[0]),
      .pull_en_i(pull_r[0]),
      .alt_en_i(pa_alt_en),
      .alt_val_i(pa_alt_val),
      .analog_i(8'h00),
      .com_en_i(8'h00),
      .pin_o(pa_pin_o),
      .pin_oe_o(pa_pin_oe_o),
      .pull_o(pa_pull_o),
      .half_o()
   );

   // Only port B carries converter inputs and LCD commons
   io_pin_cell #(.WIDTH(8)) u_pb (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .dir_i(dir_r[1]),
      .latch_i(latch_r[1]),
      .pull_en_i(pull_r[1]),
      .alt_en_i(8'h00),
      .alt_val_i(8'h00),
      .analog_i(analog_channel_config_i),
      .com_en_i(pb_com),
      .pin_o(pb_pin_o),
      .pin_oe_o(pb_pin_oe_o),
      .pull_o(pb_pull_o),
      .half_o(pb_half_o)
   );

   io_pin_cell #(.WIDTH(8)) u_pc (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .dir_i(dir_r[2]),
      .latch_i(latch_r[2]),
      .pull_en_i(pull_r[2]),
      .alt_en_i(8'h00),
      .alt_val_i(8'h00),
      .analog_i(8'h00),
      .com_en_i(8'h00),
      .pin_o(pc_pin_o),
      .pin_oe_o(pc_pin_oe_o),
      .pull_o(pc_pull_o),
      .half_o()
   );

   // Port D pins 0 to 2 double as PWM outputs
   io_pin_cell #(.WIDTH(8)) u_pd (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .dir_i(dir_r[3]),
      .latch_i(latch_r[3]),
      .pull_en_i(pull_r[3]),
      .alt_en_i(pd_alt_en),
      .alt_val_i(pd_alt_val),
      .analog_i(8'h00),
      .com_en_i(8'h00),
      .pin_o(pd_pin_o),
      .pin_oe_o(pd_pin_oe_o),
      .pull_o(pd_pull_o),
      .half_o()
   );

   io_pin_cell #(.WIDTH(8)) u_pe (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .dir_i(dir_r[4]),
      .latch_i(latch_r[4]),
      .pull_en_i(pull_r[4]),
      .alt_en_i(8'h00),
      .alt_val_i(8'h00),
      .analog_i(8'h00),
      .com_en_i(8'h00),
      .pin_o(pe_pin_o),
      .pin_oe_o(pe_pin_oe_o),
      .pull_o(pe_pull_o),
      .half_o()
   );

   // Port F has two pins; the upper register bits never reach a cell
   io_pin_cell #(.WIDTH(2)) u_pf (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .dir_i(dir_r[5][1:0]),
      .latch_i(latch_r[5][1:0]),
      .pull_en_i(pull_r[5][1:0]),
      .alt_en_i(2'h0),
      .alt_val_i(2'h0),
      .analog_i(2'h0),
      .com_en_i(2'h0),
      .pin_o(pf_pin_o),
      .pin_oe_o(pf_pin_oe_o),
      .pull_o(pf_pull_o),
      .half_o()
   );

   // ***********************************************************
   // Port A wake-up
   // ***********************************************************
   io_wake_detect #(.WIDTH(8)) u_wake (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .pin_i(pa_pin_i),
      .enable_i(wake_en_r),
      .halted_i(halted_i),
      .wake_o(wake_o)
   );

endmodule // io_port_dir_pullup_wake

// ---- sim/io_port_checker.sv ----
// Port block checker: assertions on the top module's ports
`timescale 1ns/1ps
module io_port_checker
   import io_port_pkg::*;
(
   input wire logic clock_i, // Clock
   input wire logic rst_n_i, // Reset
   input wire logic [ADDR_W-1:0] addr_i, // Address
   input wire logic rd_en_i, // Read strobe
   input wire logic [PORT_W-1:0] rd_data_o, // Read data
   input wire logic [7:0] pa_pin_i, // A levels
   input wire logic [7:0] pa_pin_o, // A drive
   input wire logic [7:0] pa_pin_oe_o, // A enable
   input wire logic [7:0] pa_pull_o, // A pull
   input wire logic [7:0] pb_pin_oe_o, // B enable
   input wire logic [7:0] pb_pull_o, // B pull
   input wire logic [7:0] pb_half_o, // B half bias
   input wire logic [7:0] pd_pin_o, // D drive
   input wire logic [7:0] pd_pin_oe_o, // D enable
   input wire logic int_enable_i, // Interrupt on
   input wire logic ext_int_o, // Interrupt level
   input wire logic [NUM_TIMERS-1:0] timer_event_mode_i, // Event modes
   input wire logic [NUM_TIMERS-1:0] timer_event_o, // Timer levels
   input wire logic pfd_select_i, // Divider chosen
   input wire logic pfd_i, // Divider value
   input wire logic [NUM_PWM-1:0] pwm_select_i, // PWM chosen
   input wire logic [NUM_PWM-1:0] pwm_i, // PWM values
   input wire logic [7:0] analog_channel_config_i, // Converter inputs
   input wire logic halted_i, // Idle or sleep
   input wire logic wake_o // Wake pulse
);
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Past guards keep values from inside reset out of the relations
   chk_unmapped_read: assert property (
      rd_en_i && addr_i[4:2] >= 3'h6 |=> rd_data_o == 8'h00)
      else $error("unmapped read not zero");
   chk_pa7_pull_absent: assert property (pa_pull_o[7] == 1'b0)
      else $error("port A pin 7 pulled high");
   chk_pull_on_output: assert property (
      (pa_pull_o & pa_pin_oe_o) == 8'h00)
      else $error("pull-high on driven pin");
   chk_int_gating: assert property ($past(rst_n_i) |->
      ext_int_o == ($past(int_enable_i) & $past(pa_pin_i[3]) & ~pa_pin_oe_o[3]))
      else $error("interrupt input gating wrong");
   chk_timer_gating: assert property ($past(rst_n_i) |->
      timer_event_o[0] == ($past(timer_event_mode_i[0]) & $past(pa_pin_i[2])
      & ~pa_pin_oe_o[2]))
      else $error("timer input gating wrong");
   chk_divider_drive: assert property (
      $past(rst_n_i) && $past(pfd_select_i) && pa_pin_oe_o[1] |-> pa_pin_o[1] == $past(pfd_i))
      else $error("divider not on pin");
   chk_pwm_drive: assert property (
      $past(rst_n_i) && $past(pwm_select_i[0]) && pd_pin_oe_o[0] |-> pd_pin_o[0] == $past(pwm_i[0]))
      else $error("pwm not on pin");
   chk_analog_pull_off: assert property ($past(rst_n_i) |->
      (pb_pull_o & $past(analog_channel_config_i)) == 8'h00)
      else $error("pull-high on converter input");
   chk_half_bias_pins: assert property (
      (pb_half_o & (pb_pin_oe_o | 8'hf0)) == 8'h00)
      else $error("half bias on wrong pin");
   chk_wake_cause: assert property (wake_o && $past(rst_n_i, 2) |->
      $past(halted_i) && (($past(pa_pin_i, 2) & ~$past(pa_pin_i)) != 8'h00))
      else $error("wake without falling edge");
endmodule // io_port_checker

bind io_port_dir_pullup_wake io_port_checker i_chk (.clock_i, .rst_n_i, .addr_i, .rd_en_i,
   .rd_data_o, .pa_pin_i, .pa_pin_o, .pa_pin_oe_o, .pa_pull_o, .pb_pin_oe_o, .pb_pull_o,
   .pb_half_o, .pd_pin_o, .pd_pin_oe_o, .int_enable_i, .ext_int_o, .timer_event_mode_i,
   .timer_event_o, .pfd_select_i, .pfd_i, .pwm_select_i, .pwm_i, .analog_channel_config_i,
   .halted_i, .wake_o);

// ---- sim/board_port_model.sv ----
// Board model: resolves one port's pin levels from chip drive, pulls and outside drivers
`timescale 1ns/1ps
module board_port_model #(
   parameter int WIDTH = 8
) (
   input wire logic clock_i, // System clock
   input wire logic [WIDTH-1:0] drive_i, // Chip drive level
   input wire logic [WIDTH-1:0] drive_en_i, // Chip drives pin
   input wire logic [WIDTH-1:0] pull_i, // Pull-high connected
   input wire logic [WIDTH-1:0] ext_en_i, // Outside driver active
   input wire logic [WIDTH-1:0] ext_val_i, // Outside driver level
   output logic [WIDTH-1:0] level_o // Resolved pin level
);
   logic [WIDTH-1:0] last_r = '0;
   // Floating pins flip every cycle so no check leans on a settled unknown
   always_comb begin
      for (int b = 0; b < WIDTH; b++) begin
         level_o[b] = drive_en_i[b] ? drive_i[b] : ext_en_i[b] ? ext_val_i[b] :
            pull_i[b] ? 1'b1 : ~last_r[b];
      end
   end
   always_ff @(posedge clock_i) begin
      last_r <= level_o;
   end
endmodule // board_port_model

// ---- sim/io_port_dir_pullup_wake_bench.sv ----
// Register-level testbench for the port block
`timescale 1ns/1ps
module io_port_dir_pullup_wake_bench
   import io_port_pkg::*;
;
   logic clock_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [4:0] addr_i = 5'h00;
   logic wr_en_i = 1'b0;
   logic rd_en_i = 1'b0;
   logic [7:0] wr_data_i = 8'h00;
   logic [7:0] rd_data_o;
   logic [7:0] pa_pin_i, pa_pin_o, pa_pin_oe_o, pa_pull_o, pb_pin_i, pb_pin_o, pb_pin_oe_o;
   logic [7:0] pb_pull_o, pb_half_o, pc_pin_i, pc_pin_o, pc_pin_oe_o, pc_pull_o, pd_pin_i;
   logic [7:0] pd_pin_o, pd_pin_oe_o, pd_pull_o, pe_pin_i, pe_pin_o, pe_pin_oe_o, pe_pull_o;
   logic [1:0] pf_pin_i, pf_pin_o, pf_pin_oe_o, pf_pull_o;
   logic int_enable_i = 1'b0;
   logic pfd_select_i = 1'b0;
   logic pfd_i = 1'b0;
   logic halted_i = 1'b0;
   logic ext_int_o, wake_o;
   logic [2:0] timer_event_mode_i = 3'h0;
   logic [2:0] pwm_select_i = 3'h0;
   logic [2:0] pwm_i = 3'h0;
   logic [2:0] timer_event_o;
   logic [7:0] analog_channel_config_i = 8'h00;
   logic [7:0] x_val [6] = '{default: 8'hff};
   logic [7:0] x_en [6] = '{default: 8'hff};
   int n_errors = 0;
   int comparisons = 0;

   io_port_dir_pullup_wake i_dut (.clock_i, .rst_n_i, .addr_i, .wr_en_i, .wr_data_i, .rd_en_i,
      .rd_data_o, .pa_pin_i, .pa_pin_o, .pa_pin_oe_o, .pa_pull_o, .pb_pin_i, .pb_pin_o,
      .pb_pin_oe_o, .pb_pull_o, .pb_half_o, .pc_pin_i, .pc_pin_o, .pc_pin_oe_o, .pc_pull_o,
      .pd_pin_i, .pd_pin_o, .pd_pin_oe_o, .pd_pull_o, .pe_pin_i, .pe_pin_o, .pe_pin_oe_o,
      .pe_pull_o, .pf_pin_i, .pf_pin_o, .pf_pin_oe_o, .pf_pull_o, .int_enable_i, .ext_int_o,
      .timer_event_mode_i, .timer_event_o, .pfd_select_i, .pfd_i, .pwm_select_i, .pwm_i,
      .analog_channel_config_i, .halted_i, .wake_o);
   board_port_model i_pa (.clock_i, .drive_i(pa_pin_o), .drive_en_i(pa_pin_oe_o),
      .pull_i(pa_pull_o), .ext_en_i(x_en[0]), .ext_val_i(x_val[0]), .level_o(pa_pin_i));
   board_port_model i_pb (.clock_i, .drive_i(pb_pin_o), .drive_en_i(pb_pin_oe_o),
      .pull_i(pb_pull_o), .ext_en_i(x_en[1]), .ext_val_i(x_val[1]), .level_o(pb_pin_i));
   board_port_model i_pc (.clock_i, .drive_i(pc_pin_o), .drive_en_i(pc_pin_oe_o),
      .pull_i(pc_pull_o), .ext_en_i(x_en[2]), .ext_val_i(x_val[2]), .level_o(pc_pin_i));
   board_port_model i_pd (.clock_i, .drive_i(pd_pin_o), .drive_en_i(pd_pin_oe_o),
      .pull_i(pd_pull_o), .ext_en_i(x_en[3]), .ext_val_i(x_val[3]), .level_o(pd_pin_i));
   board_port_model i_pe (.clock_i, .drive_i(pe_pin_o), .drive_en_i(pe_pin_oe_o),
      .pull_i(pe_pull_o), .ext_en_i(x_en[4]), .ext_val_i(x_val[4]), .level_o(pe_pin_i));
   board_port_model #(.WIDTH(2)) i_pf (.clock_i, .drive_i(pf_pin_o), .drive_en_i(pf_pin_oe_o),
      .pull_i(pf_pull_o), .ext_en_i(x_en[5][1:0]), .ext_val_i(x_val[5][1:0]), .level_o(pf_pin_i));

   always #12.5 clock_i = ~clock_i;

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge clock_i);
      addr_i <= a;
      wr_data_i <= d;
      wr_en_i <= 1'b1;
      @(posedge clock_i);
      wr_en_i <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, input logic [7:0] exp);
      @(posedge clock_i);
      addr_i <= a;
      rd_en_i <= 1'b1;
      @(posedge clock_i);
      rd_en_i <= 1'b0;
      #1 chk(rd_data_o, exp);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask
   task automatic watch_wake(input logic exp);
      logic seen;
      seen = 1'b0;
      repeat (4) begin
         @(posedge clock_i);
         #1 if (wake_o === 1'b1) seen = 1'b1;
      end
      chk({7'h00, seen}, {7'h00, exp});
   endtask
   task automatic finish_test();
      if (n_errors == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Tests take about 220 cycles; 4000, over eighteen times that, means a hang
   initial begin
      repeat (4000) @(posedge clock_i);
      n_errors++;
      finish_test();
   end

   initial begin
      repeat (12) @(posedge clock_i);
      rst_n_i <= 1'b1;
      for (int p = 0; p < 6; p++) begin
         rd(5'(p * 4 + 1), IMPL_MASK[p]);
         rd(5'(p * 4 + 2), 8'h00);
      end
      rd(5'h03, 8'h00);
      for (int a = 0; a < 32; a++) wr(5'(a), 8'hff);
      for (int p = 0; p < 6; p++) begin
         rd(5'(p * 4 + 1), IMPL_MASK[p]);
         rd(5'(p * 4 + 2), PULL_MASK[p]);
         if (p > 1) rd(5'(p * 4 + 3), 8'h00);
      end
      rd(5'h03, 8'hff);
      rd(5'h07, LCD_MASK);
      for (int a = 24; a < 32; a++) rd(5'(a), 8'h00);
      tick(2);
      chk(pa_pull_o, PULL_MASK[0]);
      chk(pc_pull_o & pd_pull_o & pe_pull_o, 8'hff);
      chk({6'h00, pf_pull_o}, 8'h03);
      chk(pb_pin_oe_o | pc_pin_oe_o | pd_pin_oe_o | pe_pin_oe_o, 8'h00);
      chk(pb_pin_o & pc_pin_o & pe_pin_o, 8'hff);
      chk({6'h00, pf_pin_oe_o | pf_pin_o}, 8'h03);
      rd(5'h14, 8'h03);
      chk(pb_half_o, 8'h0f);
      wr(5'h07, 8'h00);
      tick(2);
      chk(pb_pull_o, 8'hff);
      analog_channel_config_i <= 8'h0f;
      tick(2);
      chk(pb_pull_o, 8'hf0);
      x_val[2] <= 8'h3c;
      rd(5'h08, 8'h3c);
      wr(5'h01, 8'h00);
      wr(5'h00, 8'h5a);
      tick(2);
      chk(pa_pin_oe_o, 8'hff);
      chk(pa_pin_o, 8'h5a);
      rd(5'h00, 8'h5a);
      wr(5'h01, 8'hff);
      rd(5'h00, 8'hff);
      wr(5'h01, 8'hfd);
      int_enable_i <= 1'b1;
      x_val[0] <= 8'hf7;
      tick(3);
      chk({7'h00, ext_int_o}, 8'h00);
      x_val[0] <= 8'hff;
      timer_event_mode_i <= 3'h5;
      pfd_select_i <= 1'b1;
      tick(3);
      chk({7'h00, ext_int_o}, 8'h01);
      chk({5'h00, timer_event_o}, 8'h05);
      chk(pa_pin_o & 8'h02, 8'h00);
      wr(5'h01, 8'hf5);
      tick(3);
      chk({7'h00, ext_int_o}, 8'h00);
      pfd_select_i <= 1'b0;
      tick(3);
      chk(pa_pin_o, 8'h5a);
      wr(5'h0d, 8'h00);
      pwm_select_i <= 3'h7;
      pwm_i <= 3'h2;
      tick(3);
      chk(pd_pin_o, 8'hfa);
      wr(5'h0d, 8'hff);
      tick(2);
      chk(pd_pin_oe_o, 8'h00);
      wr(5'h01, 8'hff);
      wr(5'h03, 8'h01);
      halted_i <= 1'b1;
      tick(2);
      x_val[0] <= 8'hfd;
      watch_wake(1'b0);
      x_val[0] <= 8'hfc;
      watch_wake(1'b1);
      finish_test();
   end
endmodule // io_port_dir_pullup_wake_bench
